// ### common/fslb_defines.vh
// Constants for the flash command sequencer with lock and blank check
`ifndef FSLB_DEFINES_VH
`define FSLB_DEFINES_VH
`define FSLB_NUM_BLOCKS     8
`define FSLB_BLK_W          3
`define FSLB_ADDR_W         16
`define FSLB_BLK_LSB        12
`define FSLB_BLK_TOP_OFS    12'hFFE
`define FSLB_CMD_READ_ARRAY 8'hFF
`define FSLB_CMD_READ_STAT  8'h70
`define FSLB_CMD_CLR_STAT   8'h50
`define FSLB_CMD_PROGRAM    8'h41
`define FSLB_CMD_ERASE      8'h20
`define FSLB_CMD_LOCK_PROG  8'h77
`define FSLB_CMD_READ_LOCK  8'h71
`define FSLB_CMD_BLANK      8'h25
`define FSLB_CMD_CONFIRM    8'hD0
`define FSLB_ST_READY_BIT   7
`define FSLB_ST_ERASE_BIT   5
`define FSLB_ST_PROG_BIT    4
`define FSLB_LOCK_RESET     8'hFF
`define FSLB_OP_TIME_NS     40
`define FSLB_CLK_PERIOD_NS  4
`define FSLB_OP_CYCLES      (`FSLB_OP_TIME_NS / `FSLB_CLK_PERIOD_NS)
`define FSLB_OPC_W          3
`define FSLB_OP_PROGRAM     3'h1
`define FSLB_OP_ERASE       3'h2
`define FSLB_OP_LOCK_PROG   3'h3
`define FSLB_OP_READ_LOCK   3'h4
`define FSLB_OP_BLANK       3'h5
`endif

// ### logic/fslb_lock_bits.v
// Per-block lock bit store with lock-disable gating
`timescale 1ns/1ps
`include "fslb_defines.vh"
module fslb_lock_bits (
   input  wire                     i_clk,
   input  wire                     i_rst,
   input  wire                     i_lock_disable,
   input  wire                     i_clear_en,
   input  wire                     i_set_en,
   input  wire [`FSLB_BLK_W-1:0]   i_blk,
   output wire                     o_locked,
   output wire                     o_stored
);
   reg  [`FSLB_NUM_BLOCKS-1:0] lock_r;
   wire [`FSLB_NUM_BLOCKS-1:0] lock_init = `FSLB_LOCK_RESET;
   genvar g;
   // Reset stands in for nonvolatile content; a real array keeps it across power
   generate
      for (g = 0; g < `FSLB_NUM_BLOCKS; g = g + 1) begin : g_lock
         always @(posedge i_clk) begin
            if (i_rst) begin
               lock_r[g] <= lock_init[g];
            end else if (i_blk == g) begin
               if (i_clear_en) begin
                  lock_r[g] <= 1'b0;
               end else if (i_set_en) begin
                  lock_r[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate
   assign o_stored = lock_r[i_blk];
   assign o_locked = ~lock_r[i_blk] & ~i_lock_disable;
endmodule

// ### logic/fslb_op_timer.v
// Countdown timer for the duration of an automatic operation
`timescale 1ns/1ps
`include "fslb_defines.vh"
module fslb_op_timer (
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_start,
   output wire o_done
);
   localparam integer LOAD_I = `FSLB_OP_CYCLES;
   localparam [7:0]   LOAD   = LOAD_I[7:0];
   reg  [7:0] cnt_r;
   always @(posedge i_clk) begin
      if (i_rst) begin
         cnt_r <= 8'h00;
      end else if (i_start) begin
         cnt_r <= LOAD;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   assign o_done = (cnt_r == 8'h01);
endmodule

// ### logic/fslb_sequencer.v
// Flash command sequencer: decode, status byte, lock protection, blank check
`timescale 1ns/1ps
`include "fslb_defines.vh"
module fslb_sequencer (
   input  wire                     I_REF_CLK,
   input  wire                     I_SYS_RST,
   input  wire                     i_wr,
   input  wire                     i_rd,
   input  wire [`FSLB_ADDR_W-1:0]  i_addr,
   input  wire [15:0]              i_wdata,
   input  wire                     i_erase_write_mode_a,
   input  wire                     i_lock_disable_bit,
   input  wire                     i_blank_result,
   input  wire                     i_verify_fail,
   input  wire [15:0]              i_array_rdata,
   output reg  [15:0]              o_rdata,
   output wire                     o_seq_ready_flag,
   output wire                     o_erase_error_flag,
   output wire                     o_program_error_flag,
   output wire [7:0]               o_flash_status_byte,
   output wire                     o_lock_status,
   output wire                     o_op_start,
   output wire [`FSLB_OPC_W-1:0]   o_op_code,
   output wire [`FSLB_BLK_W-1:0]   o_op_block
);
   localparam [1:0] S_IDLE   = 2'h0;
   localparam [1:0] S_SECOND = 2'h1;
   localparam [1:0] S_PROG2  = 2'h2;
   localparam [1:0] S_BUSY   = 2'h3;

   reg  [1:0]              state_r;
   reg  [1:0]              state_nxt;
   reg  [7:0]              first_r;
   reg  [`FSLB_BLK_W-1:0]  blk_r;
   reg  [`FSLB_OPC_W-1:0]  op_r;
   reg  [`FSLB_OPC_W-1:0]  op_nxt;
   reg                     ready_r;
   reg                     erase_err_r;
   reg                     prog_err_r;
   reg                     stat_mode_r;
   reg                     lock_stat_r;
   reg                     start_r;
   reg                     start_nxt;
   reg                     set_ee;
   reg                     set_pe;
   reg                     clr_err;
   reg                     to_stat;
   reg                     to_array;
   reg                     fail_now;
   reg  [`FSLB_OPC_W-1:0]  first_op;
   reg  [7:0]              stat_byte;

   // Only the low byte carries a command; the upper byte is don't-care
   wire [7:0]              code   = i_wdata[7:0];
   wire                    even   = ~i_addr[0];
   wire                    wr_ok  = i_wr & even;
   wire                    errors = erase_err_r | prog_err_r;
   wire [`FSLB_BLK_W-1:0]  a_blk  = i_addr[`FSLB_BLK_LSB+`FSLB_BLK_W-1:`FSLB_BLK_LSB];
   wire                    at_top = (i_addr[`FSLB_BLK_LSB-1:0] == `FSLB_BLK_TOP_OFS);
   wire                    op_done;
   wire                    blk_locked;
   wire                    blk_stored;
   // Lock lookup follows the frozen target while an operation runs
   wire [`FSLB_BLK_W-1:0]  lk_blk = (state_r == S_BUSY) ? blk_r : a_blk;
   wire                    lock_clr = op_done & (op_r == `FSLB_OP_LOCK_PROG) & ~fail_now;
   wire                    lock_set = op_done & (op_r == `FSLB_OP_ERASE) & ~fail_now;
   wire                    blank_fail = ~blk_stored | ~i_blank_result;

   fslb_lock_bits u_fslb_lock_bits (
      .i_clk          (I_REF_CLK),
      .i_rst          (I_SYS_RST),
      .i_lock_disable (i_lock_disable_bit),
      .i_clear_en     (lock_clr),
      .i_set_en       (lock_set),
      .i_blk          (lk_blk),
      .o_locked       (blk_locked),
      .o_stored       (blk_stored)
   );

   // Timer loads on the launching edge so done meets the ready update
   fslb_op_timer u_fslb_op_timer (
      .i_clk   (I_REF_CLK),
      .i_rst   (I_SYS_RST),
      .i_start (start_nxt),
      .o_done  (op_done)
   );

   // Failure of the finishing lock-program or erase operation, taken from i_verify_fail
   always @* begin
      fail_now = 1'b0;
      case (op_r)
         `FSLB_OP_LOCK_PROG: fail_now = i_verify_fail;
         `FSLB_OP_ERASE:     fail_now = i_verify_fail;
         default:            fail_now = 1'b0;
      endcase
   end

   // Operation that a confirmed second cycle launches
   always @* begin
      case (first_r)
         `FSLB_CMD_ERASE:     first_op = `FSLB_OP_ERASE;
         `FSLB_CMD_LOCK_PROG: first_op = `FSLB_OP_LOCK_PROG;
         `FSLB_CMD_READ_LOCK: first_op = `FSLB_OP_READ_LOCK;
         default:             first_op = `FSLB_OP_BLANK;
      endcase
   end

   always @* begin
      state_nxt = state_r;
      op_nxt    = op_r;
      start_nxt = 1'b0;
      set_ee    = 1'b0;
      set_pe    = 1'b0;
      clr_err   = 1'b0;
      to_stat   = 1'b0;
      to_array  = 1'b0;
      case (state_r)
         S_IDLE: begin
            // Guarded first cycles are dropped silently while an error is latched
            if (wr_ok) begin
               case (code)
                  `FSLB_CMD_READ_ARRAY: to_array = 1'b1;
                  `FSLB_CMD_READ_STAT:  to_stat = 1'b1;
                  `FSLB_CMD_CLR_STAT:   clr_err = 1'b1;
                  `FSLB_CMD_PROGRAM: begin
                     if (!errors) begin
                        state_nxt = S_PROG2;
                     end
                  end
                  `FSLB_CMD_ERASE, `FSLB_CMD_LOCK_PROG,
                  `FSLB_CMD_READ_LOCK, `FSLB_CMD_BLANK: begin
                     if (!errors) begin
                        state_nxt = S_SECOND;
                     end
                  end
                  default: begin
                     set_ee = 1'b1;
                     set_pe = 1'b1;
                  end
               endcase
            end
         end
         S_SECOND: begin
            if (wr_ok) begin
               state_nxt = S_IDLE;
               if (code == `FSLB_CMD_READ_ARRAY) begin
                  to_array = 1'b1;
               end else if (code != `FSLB_CMD_CONFIRM || !at_top) begin
                  set_ee = 1'b1;
                  set_pe = 1'b1;
               end else begin
                  op_nxt = first_op;
                  // Locked erase targets fail at once unless lock disable is set
                  if (blk_locked && first_r == `FSLB_CMD_ERASE) begin
                     set_ee = 1'b1;
                  end else begin
                     state_nxt = S_BUSY;
                     start_nxt = 1'b1;
                  end
                  if (first_r != `FSLB_CMD_READ_LOCK) begin
                     to_stat = 1'b1;
                  end
               end
            end
         end
         S_PROG2: begin
            // Lock is checked on the block named by the data write
            if (wr_ok) begin
               op_nxt  = `FSLB_OP_PROGRAM;
               to_stat = 1'b1;
               if (blk_locked) begin
                  state_nxt = S_IDLE;
                  set_pe    = 1'b1;
               end else begin
                  state_nxt = S_BUSY;
                  start_nxt = 1'b1;
               end
            end
         end
         S_BUSY: begin
            // Writes here are dropped so the running operation stays intact
            if (op_done) begin
               state_nxt = S_IDLE;
               case (op_r)
                  `FSLB_OP_BLANK: begin
                     // Raw stored bit: locked block is never reported blank
                     if (blank_fail) begin
                        set_ee = 1'b1;
                     end
                  end
                  `FSLB_OP_ERASE:     set_ee = i_verify_fail;
                  `FSLB_OP_PROGRAM:   set_pe = i_verify_fail;
                  `FSLB_OP_LOCK_PROG: set_pe = i_verify_fail;
                  default:            set_ee = 1'b0;
               endcase
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         state_r     <= S_IDLE;
         first_r     <= 8'h00;
         blk_r       <= {`FSLB_BLK_W{1'b0}};
         op_r        <= {`FSLB_OPC_W{1'b0}};
         ready_r     <= 1'b1;
         erase_err_r <= 1'b0;
         prog_err_r  <= 1'b0;
         stat_mode_r <= 1'b0;
         lock_stat_r <= 1'b0;
         start_r     <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r    <= op_nxt;
         start_r <= start_nxt;
         // First cycle code is kept for the second cycle decode
         if (state_r == S_IDLE && wr_ok) begin
            first_r <= code;
         end
         // Target block is frozen for the whole operation
         if (state_r != S_BUSY && wr_ok) begin
            blk_r <= a_blk;
         end
         ready_r <= (state_nxt != S_BUSY);
         // Set wins over clear so a finishing error is never lost
         if (set_ee) begin
            erase_err_r <= 1'b1;
         end else if (clr_err) begin
            erase_err_r <= 1'b0;
         end
         if (set_pe) begin
            prog_err_r <= 1'b1;
         end else if (clr_err) begin
            prog_err_r <= 1'b0;
         end
         // Status mode outlives completion so polling needs no new command
         if (to_array) begin
            stat_mode_r <= 1'b0;
         end else if (to_stat) begin
            stat_mode_r <= 1'b1;
         end
         if (op_done && op_r == `FSLB_OP_READ_LOCK) begin
            lock_stat_r <= blk_stored;
         end
      end
   end

   // Reserved positions read as zero
   always @* begin
      stat_byte                     = 8'h00;
      stat_byte[`FSLB_ST_READY_BIT] = ready_r;
      stat_byte[`FSLB_ST_ERASE_BIT] = erase_err_r;
      stat_byte[`FSLB_ST_PROG_BIT]  = prog_err_r;
   end
   assign o_flash_status_byte = stat_byte;

   // Read data registered; status appears on even reads in status mode while in mode 0
   always @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         if (i_erase_write_mode_a && stat_mode_r && even) begin
            o_rdata <= {8'h00, o_flash_status_byte};
         end else begin
            o_rdata <= i_array_rdata;
         end
      end
   end

   assign o_seq_ready_flag     = ready_r;
   assign o_erase_error_flag   = erase_err_r;
   assign o_program_error_flag = prog_err_r;
   assign o_lock_status        = lock_stat_r;
   assign o_op_start           = start_r;
   assign o_op_code            = op_r;
   assign o_op_block           = blk_r;
endmodule

// ### test/fslb_monitor.sv
// Port-level assertions for the flash command sequencer
`timescale 1ns/1ps
`include "fslb_defines.vh"
module fslb_monitor (
   input wire logic       I_REF_CLK,
   input wire logic       I_SYS_RST,
   input wire logic       i_blank_result,
   input wire logic       i_verify_fail,
   input wire logic       o_seq_ready_flag,
   input wire logic       o_erase_error_flag,
   input wire logic       o_program_error_flag,
   input wire logic [7:0] o_flash_status_byte,
   input wire logic       o_lock_status,
   input wire logic       o_op_start,
   input wire logic [2:0] o_op_code
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SYS_RST);
   a_start_busy: assert property (o_op_start |-> !o_seq_ready_flag)
      else $error("ready flag high at op start");
   a_op_length: assert property (o_op_start |-> (!o_seq_ready_flag)[*8] ##1
      (!o_seq_ready_flag)[*2] ##1 o_seq_ready_flag) else $error("op length wrong");
   a_stat_layout: assert property (o_flash_status_byte == {o_seq_ready_flag, 1'h0,
      o_erase_error_flag, o_program_error_flag, 4'h0}) else $error("status byte layout");
   a_reset_values: assert property ($past(I_SYS_RST) |-> o_seq_ready_flag &&
      !o_erase_error_flag && !o_program_error_flag) else $error("status reset value");
   a_err_blocks: assert property ((o_erase_error_flag || o_program_error_flag)
      |=> !o_op_start) else $error("op launched with error flag set");
   a_busy_ignore: assert property (!o_seq_ready_flag && !o_op_start |=> !o_op_start)
      else $error("op launched while busy");
   a_flags_busy: assert property (!o_seq_ready_flag && !$past(o_seq_ready_flag)
      |-> $stable(o_erase_error_flag) && $stable(o_program_error_flag))
      else $error("error flags moved mid op");
   a_lock_update: assert property ($changed(o_lock_status) |-> $rose(o_seq_ready_flag)
      && o_op_code == `FSLB_OP_READ_LOCK) else $error("lock status moved outside read");
   a_blank_error: assert property ($rose(o_seq_ready_flag) && o_op_code == `FSLB_OP_BLANK
      && !$past(i_blank_result) |-> o_erase_error_flag && !o_program_error_flag)
      else $error("non-blank result not flagged");
   a_prog_verify: assert property ($rose(o_seq_ready_flag) && o_op_code ==
      `FSLB_OP_PROGRAM && $past(i_verify_fail) |-> o_program_error_flag &&
      !o_erase_error_flag) else $error("program verify fail not flagged");
endmodule
bind fslb_sequencer fslb_monitor u_fslb_monitor (.I_REF_CLK(I_REF_CLK),
   .I_SYS_RST(I_SYS_RST), .i_blank_result(i_blank_result), .i_verify_fail(i_verify_fail),
   .o_seq_ready_flag(o_seq_ready_flag), .o_erase_error_flag(o_erase_error_flag),
   .o_program_error_flag(o_program_error_flag), .o_flash_status_byte(o_flash_status_byte),
   .o_lock_status(o_lock_status), .o_op_start(o_op_start), .o_op_code(o_op_code));

// ### test/fslb_host_model.sv
// Host model issuing flash command writes and status reads
`timescale 1ns/1ps
module fslb_host_model (
   input  wire logic        I_REF_CLK,
   input  wire logic        i_ready,
   output logic             o_wr,
   output logic             o_rd,
   output logic [15:0]      o_addr,
   output logic [15:0]      o_wdata
);
   initial begin
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_addr = 16'h0000;
      o_wdata = 16'h0000;
   end
   // One-cycle strobe; the idle edge on entry keeps back-to-back calls race free
   task automatic cycle(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge I_REF_CLK) #1;
      o_addr = {a[15:1], 1'h0};
      o_wdata = d;
      o_wr = w;
      o_rd = !w;
      @(posedge I_REF_CLK) #1;
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
   endtask
   task automatic wait_ready(output logic ok);
      ok = 1'h0;
      repeat (40) begin
         if (!ok && i_ready === 1'h1) ok = 1'h1;
         if (!ok) @(posedge I_REF_CLK) #1;
      end
   endtask
endmodule

// ### test/flash_status_lock_blank_check_tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "fslb_defines.vh"
module flash_status_lock_blank_check_tb;
   logic        I_REF_CLK, I_SYS_RST, i_wr, i_rd, ew0, lock_dis, blank, vfail;
   logic        rdy, eerr, perr, lock_st, op_start, rd_q, ok;
   logic [15:0] i_addr, i_wdata, o_rdata, arr;
   logic [7:0]  stat, lfsr;
   logic [2:0]  op_code, op_blk;
   logic [15:0] exp_rd[$];
   logic [15:0] exp_op[$];
   int          n_fail, checks_done;
   fslb_sequencer u_fslb_sequencer (.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST),
      .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_erase_write_mode_a(ew0), .i_lock_disable_bit(lock_dis), .i_blank_result(blank),
      .i_verify_fail(vfail), .i_array_rdata(arr), .o_rdata(o_rdata),
      .o_seq_ready_flag(rdy), .o_erase_error_flag(eerr), .o_program_error_flag(perr),
      .o_flash_status_byte(stat), .o_lock_status(lock_st), .o_op_start(op_start),
      .o_op_code(op_code), .o_op_block(op_blk));
   fslb_host_model u_fslb_host_model (.I_REF_CLK(I_REF_CLK), .i_ready(rdy), .o_wr(i_wr),
      .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Random upper byte must be ignored by the decoder
   task automatic cmd(input logic [15:0] a, input logic [7:0] c);
      lfsr = lfsr_next(lfsr);
      u_fslb_host_model.cycle(1'h1, a, {lfsr, c});
   endtask
   task automatic wait_rdy;
      u_fslb_host_model.wait_ready(ok);
      if (!ok) begin
         n_fail++;
         end_of_test();
      end
   endtask
   task automatic rd_e(input logic [15:0] e);
      exp_rd.push_back(e);
      u_fslb_host_model.cycle(1'h0, 16'h0002, 16'h0000);
   endtask
   task automatic st(input logic [7:0] e);
      cmd(16'h0000, `FSLB_CMD_READ_STAT);
      rd_e({8'h00, e});
   endtask
   task automatic launch(input logic [7:0] c, input logic [2:0] b, input logic [2:0] op,
                         input logic go, input logic [7:0] second);
      cmd(16'h0000, c);
      cmd({1'h0, b, `FSLB_BLK_TOP_OFS}, second);
      if (go) exp_op.push_back({10'h000, op, b});
      if (go) wait_rdy();
   endtask
   always @(posedge I_REF_CLK) begin
      if (rd_q === 1'h1) check("rdata", exp_rd.pop_front(), o_rdata);
      rd_q <= i_rd;
      if (op_start === 1'h1) check("op", exp_op.pop_front(), {10'h000, op_code, op_blk});
   end
   initial begin
      I_REF_CLK = 1'h0;
      forever #2 I_REF_CLK = ~I_REF_CLK;
   end
   initial begin
      {I_SYS_RST, ew0, lock_dis, blank, vfail} = 5'h1A;
      arr = 16'h5A3C;
      lfsr = 8'h1D;
      n_fail = 0;
      checks_done = 0;
      repeat (4) @(posedge I_REF_CLK);
      #1 I_SYS_RST = 1'h0;
      st(8'h80);
      ew0 = 1'h0;
      rd_e(arr);
      ew0 = 1'h1;
      launch(`FSLB_CMD_BLANK, 3'h1, `FSLB_OP_BLANK, 1'h1, `FSLB_CMD_CONFIRM);
      rd_e(16'h0080);
      blank = 1'h0;
      launch(`FSLB_CMD_BLANK, 3'h1, `FSLB_OP_BLANK, 1'h1, `FSLB_CMD_CONFIRM);
      rd_e(16'h00A0);
      cmd(16'h0000, `FSLB_CMD_BLANK);
      cmd(16'h0000, `FSLB_CMD_CLR_STAT);
      st(8'h80);
      launch(`FSLB_CMD_BLANK, 3'h1, `FSLB_OP_BLANK, 1'h0, 8'h12);
      st(8'hB0);
      cmd(16'h0000, `FSLB_CMD_CLR_STAT);
      launch(`FSLB_CMD_BLANK, 3'h1, `FSLB_OP_BLANK, 1'h0, `FSLB_CMD_READ_ARRAY);
      rd_e(arr);
      blank = 1'h1;
      launch(`FSLB_CMD_LOCK_PROG, 3'h2, `FSLB_OP_LOCK_PROG, 1'h1, `FSLB_CMD_CONFIRM);
      launch(`FSLB_CMD_READ_LOCK, 3'h2, `FSLB_OP_READ_LOCK, 1'h1, `FSLB_CMD_CONFIRM);
      check("lock", 16'h0000, {15'h0000, lock_st});
      for (int i = 0; i < 2; i++) begin
         lock_dis = i[0];
         launch(`FSLB_CMD_BLANK, 3'h2, `FSLB_OP_BLANK, 1'h1, `FSLB_CMD_CONFIRM);
         st(8'hA0);
         cmd(16'h0000, `FSLB_CMD_CLR_STAT);
      end
      lock_dis = 1'h0;
      launch(`FSLB_CMD_ERASE, 3'h2, `FSLB_OP_ERASE, 1'h0, `FSLB_CMD_CONFIRM);
      st(8'hA0);
      cmd(16'h0000, `FSLB_CMD_CLR_STAT);
      lock_dis = 1'h1;
      launch(`FSLB_CMD_ERASE, 3'h2, `FSLB_OP_ERASE, 1'h1, `FSLB_CMD_CONFIRM);
      st(8'h80);
      lock_dis = 1'h0;
      launch(`FSLB_CMD_READ_LOCK, 3'h2, `FSLB_OP_READ_LOCK, 1'h1, `FSLB_CMD_CONFIRM);
      check("lock", 16'h0001, {15'h0000, lock_st});
      vfail = 1'h1;
      cmd(16'h0004, `FSLB_CMD_PROGRAM);
      u_fslb_host_model.cycle(1'h1, 16'h0004, 16'h1234);
      exp_op.push_back({10'h000, `FSLB_OP_PROGRAM, 3'h0});
      wait_rdy();
      st(8'h90);
      cmd(16'h0000, `FSLB_CMD_CLR_STAT);
      vfail = 1'h0;
      launch(`FSLB_CMD_BLANK, 3'h1, `FSLB_OP_BLANK, 1'h0, `FSLB_CMD_CONFIRM);
      exp_op.push_back({10'h000, `FSLB_OP_BLANK, 3'h1});
      launch(`FSLB_CMD_BLANK, 3'h3, `FSLB_OP_BLANK, 1'h0, `FSLB_CMD_CONFIRM);
      wait_rdy();
      st(8'h80);
      repeat (3) @(posedge I_REF_CLK);
      check("pending", 16'h0000, 16'(exp_rd.size() + exp_op.size()));
      end_of_test();
   end
endmodule
